// ### logic/sfd_bank.sv
// Special-function register bank: decode, bit access, safe-mode write guard and read mux.
//
// Behaviour
// - Registers decode only at 80H-FFH and only on direct-address accesses.
// - Addresses ending 0 or 8 allow single-bit writes, other bits untouched.
// - Addresses not a multiple of eight accept whole bytes only.
// - Global, clock and wake configuration writes land only in safe mode.
// - Serial clock divider and slave preset value share one storage byte.
// - Shared addresses read the read-only register, write the write-only one.
// - Write-only bits store, read-only bits ignore writes, read-write bits read back.
// - Reset clears the auxiliary operand, accumulator and status word.
// - Global configuration resets to 80H, plus boot bit 5 and small-variant bit 6.
// - The unlock register resets to zero, so safe mode starts inactive.
// - The shared location reads a fixed identification code per variant.
`timescale 1ns/1ps
module sfd_bank #(
  parameter int SAFE_CYCLES = sfd_pkg::SFD_SAFE_CYCLES,
  parameter bit SMALL_VARIANT = 1'b0
) (
  // Clock and reset.
  input wire logic mclk,
  input wire logic rst_n,
  // Straps sampled at reset.
  input wire logic boot_start,
  // Core access port.
  input sfd_pkg::sfd_req_t req,
  output logic [7:0] rdata,
  output logic rvalid,
  // Flash status from the flash controller.
  input wire logic [7:0] flash_status,
  // Core registers.
  output logic [7:0] acc,
  output logic [7:0] program_status_word,
  output logic [7:0] aux_b,
  // Configuration levels.
  output sfd_pkg::sfd_cfg_t cfg
);
  import sfd_pkg::*;

  // The safe-mode counter is eight bits wide, so longer windows cannot be counted.
  if (SAFE_CYCLES < 1 || SAFE_CYCLES > 255) begin : g_bad_safe_len
    $error("SAFE_CYCLES must lie between 1 and 255");
  end

  localparam logic [7:0] SAFE_LEN = 8'(SAFE_CYCLES);
  localparam logic [7:0] PART_ID = SMALL_VARIANT ? SFD_ID_SMALL : SFD_ID_LARGE;

  typedef struct packed {
    logic [7:0] acc;
    logic [7:0] program_status_word;
    logic [7:0] auxb;
    logic [7:0] gcfg;
    logic [7:0] clkcfg;
    logic [7:0] wake;
    logic [7:0] unlock;
    logic [7:0] sclkdiv;
    logic [7:0] flash_ctrl;
    sfd_unlock_t mode;
    logic [7:0] safe_cnt;
    logic safe;
    logic [7:0] rdata;
    logic rvalid;
  } sfd_state_t;

  sfd_state_t q;
  sfd_state_t next_q;
  sfd_sel_t sel;
  logic wr_ok;
  logic safe;

  sfd_decode u_decode (
    .req(req),
    .sel(sel)
  );

  // A bit write is honoured only at bit-addressable locations; elsewhere it is dropped whole.
  assign wr_ok = req.wr && sel.hit && (!req.bit_op || sel.bitable);
  assign safe = q.safe; // Registered copy of the mode decode, so the output comes from a flop.

  // Byte or single-bit write value built from the register's current contents.
  function automatic logic [7:0] wval(input logic [7:0] old, input sfd_req_t r);
    return r.bit_op ? sfd_merge_bit(old, r.bit_idx, r.bit_val) : r.wdata;
  endfunction

  // Next-state logic for storage, unlock sequencer and read data.
  always_comb begin
    next_q = q;
    next_q.rvalid = req.rd;
    next_q.rdata = 8'h00;
    // Storage updates.
    if (wr_ok && sel.acc) begin
      next_q.acc = wval(q.acc, req);
    end
    if (wr_ok && sel.program_status_word) begin
      next_q.program_status_word = wval(q.program_status_word, req);
    end
    if (wr_ok && sel.auxb) begin
      next_q.auxb = wval(q.auxb, req);
    end
    // Both serial aliases decode to this single byte.
    if (wr_ok && sel.sclkdiv) begin
      next_q.sclkdiv = req.wdata;
    end
    // Write side of the flash pair; the status side is read-only.
    if (wr_ok && sel.flash) begin
      next_q.flash_ctrl = req.wdata;
    end
    // Protected registers change only while the safe window is open.
    if (wr_ok && safe && sel.gcfg) begin
      next_q.gcfg = req.wdata;
    end
    if (wr_ok && safe && sel.clkcfg) begin
      next_q.clkcfg = req.wdata;
    end
    if (wr_ok && safe && sel.wake) begin
      next_q.wake = req.wdata;
    end
    // The safe window closes by itself so a runaway program cannot keep it open.
    if (q.mode == SFD_SAFE) begin
      if (q.safe_cnt == 8'h01) begin
        next_q.mode = SFD_LOCKED;
        next_q.safe_cnt = 8'h00;
      end else begin
        next_q.safe_cnt = q.safe_cnt - 8'h01;
      end
    end
    // Unlock register stores writes and advances the two-key sequence.
    if (wr_ok && sel.shared_id) begin
      next_q.unlock = req.wdata;
      case (q.mode)
        SFD_LOCKED: begin
          next_q.mode = (req.wdata == SFD_KEY1) ? SFD_KEY1_SEEN : SFD_LOCKED;
        end
        SFD_KEY1_SEEN: begin
          if (req.wdata == SFD_KEY2) begin
            next_q.mode = SFD_SAFE;
            next_q.safe_cnt = SAFE_LEN;
          end else begin
            next_q.mode = (req.wdata == SFD_KEY1) ? SFD_KEY1_SEEN : SFD_LOCKED;
          end
        end
        SFD_SAFE: begin
          // A key write on the last open cycle must not revive an expiring window.
          next_q.mode = (q.safe_cnt == 8'h01) ? SFD_LOCKED : SFD_SAFE;
        end
        default: begin
          next_q.mode = SFD_LOCKED;
        end
      endcase
    end
    // The safe flag follows the next mode so that it is a plain flop at the output.
    next_q.safe = (next_q.mode == SFD_SAFE);
    // Read mux; write-only storage is never returned.
    if (req.rd && sel.hit) begin
      if (sel.shared_id) begin
        next_q.rdata = PART_ID;
      end else if (sel.flash) begin
        next_q.rdata = flash_status;
      end else if (sel.acc) begin
        next_q.rdata = q.acc;
      end else if (sel.program_status_word) begin
        next_q.rdata = q.program_status_word;
      end else if (sel.auxb) begin
        next_q.rdata = q.auxb;
      end else if (sel.gcfg) begin
        next_q.rdata = q.gcfg;
      end else if (sel.clkcfg) begin
        next_q.rdata = q.clkcfg;
      end else if (sel.wake) begin
        next_q.rdata = q.wake;
      end else if (sel.sclkdiv) begin
        next_q.rdata = q.sclkdiv;
      end
    end
  end

  // State register with synchronous reset; the boot strap is sampled at the reset edge.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      q <= '0;
      q.acc <= SFD_RST_CORE;
      q.program_status_word <= SFD_RST_CORE;
      q.auxb <= SFD_RST_CORE;
      q.gcfg <= SFD_RST_GCFG;
      q.gcfg[SFD_GCFG_BOOT_BIT] <= boot_start;
      q.gcfg[SFD_GCFG_SMALL_BIT] <= SMALL_VARIANT;
      q.clkcfg <= SFD_RST_CLKCFG;
      q.wake <= SFD_RST_WAKE;
      q.unlock <= SFD_RST_UNLOCK;
      q.sclkdiv <= SFD_RST_SCLKDIV;
      q.flash_ctrl <= SFD_RST_FLASH;
      q.mode <= SFD_LOCKED;
    end else begin
      q <= next_q;
    end
  end

  // Outputs come straight from the state register.
  assign rdata = q.rdata;
  assign rvalid = q.rvalid;
  assign acc = q.acc;
  assign program_status_word = q.program_status_word;
  assign aux_b = q.auxb;
  assign cfg.safe_active = safe;
  assign cfg.gcfg = q.gcfg;
  assign cfg.clkcfg = q.clkcfg;
  assign cfg.wake = q.wake;
  assign cfg.sclkdiv = q.sclkdiv;
  assign cfg.flash_ctrl = q.flash_ctrl;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  // A byte write to the selected register while safe mode is not active.
  sequence s_locked_wr(logic s);
    req.wr && s && !req.bit_op && q.mode != SFD_SAFE;
  endsequence

  a_indirect_ignored: assert property (req.wr && !req.direct |=> $stable(q.acc) && $stable(q.program_status_word))
    else $error("indirect write changed a register");
  a_low_half_ignored: assert property (req.rd && req.addr < SFD_WIN_BASE |=> rdata == 8'h00)
    else $error("register read below the window");
  a_bit_write_merge: assert property (wr_ok && sel.acc && req.bit_op
      |=> acc == sfd_merge_bit($past(acc), $past(req.bit_idx), $past(req.bit_val)))
    else $error("bit write disturbed other bits");
  a_bit_refused: assert property (req.wr && req.bit_op && sel.hit && !sel.bitable |=> $stable(cfg.sclkdiv))
    else $error("bit write accepted at byte-only address");
  a_cfg_locked: assert property (s_locked_wr(sel.gcfg) |=> $stable(cfg.gcfg))
    else $error("protected write landed outside safe mode");
  a_cfg_unlocked: assert property (req.wr && sel.clkcfg && !req.bit_op && safe
      |=> cfg.clkcfg == $past(req.wdata))
    else $error("safe-mode write lost");
  a_alias_store: assert property (req.wr && sel.sclkdiv && !req.bit_op ##1 req.rd && sel.sclkdiv
      |=> rdata == $past(req.wdata, 2))
    else $error("alias did not read back");
  a_shared_read: assert property (req.rd && sel.shared_id |=> rvalid && rdata == PART_ID)
    else $error("identification code wrong");
  a_flash_pair: assert property (req.rd && sel.flash |=> rdata == $past(flash_status))
    else $error("flash pair read the write side");
  a_core_reset: assert property (@(posedge mclk) disable iff (1'b0) !rst_n |=> acc == 8'h00 && program_status_word == 8'h00
      && aux_b == 8'h00 && !cfg.safe_active && cfg.gcfg[7])
    else $error("core registers not cleared by reset");
  a_safe_window: assert property ($rose(safe) |-> safe [*8])
    else $error("safe window closed early");
  a_unlock_store: assert property (wr_ok && sel.shared_id |=> q.unlock == $past(req.wdata))
    else $error("unlock write not stored");
  a_unlock_reset: assert property (@(posedge mclk) disable iff (1'b0) !rst_n |=> q.unlock == 8'h00 && !safe)
    else $error("unlock register not cleared by reset");

endmodule

// ### logic/sfd_decode.sv
// Address decoder for the special-function register window.
`timescale 1ns/1ps
module sfd_decode (
  // Access from the core.
  input sfd_pkg::sfd_req_t req,
  // Register selects.
  output sfd_pkg::sfd_sel_t sel
);
  import sfd_pkg::*;

  logic in_win;

  // Only direct accesses in the upper half reach the registers; indirect ones land in RAM.
  assign in_win = req.direct && (req.addr >= SFD_WIN_BASE);

  // Every select is gated by the window hit, so an indirect access selects nothing.
  always_comb begin
    sel = '0;
    sel.hit = in_win;
    sel.bitable = in_win && sfd_bit_addressable(req.addr);
    sel.flash = in_win && (req.addr == SFD_ADDR_FLASH);
    sel.shared_id = in_win && (req.addr == SFD_ADDR_SHARED_ID);
    sel.wake = in_win && (req.addr == SFD_ADDR_WAKE);
    sel.gcfg = in_win && (req.addr == SFD_ADDR_GCFG);
    sel.clkcfg = in_win && (req.addr == SFD_ADDR_CLKCFG);
    sel.program_status_word = in_win && (req.addr == SFD_ADDR_PSW);
    sel.acc = in_win && (req.addr == SFD_ADDR_ACC);
    sel.auxb = in_win && (req.addr == SFD_ADDR_AUXB);
    sel.sclkdiv = in_win && (req.addr == SFD_ADDR_SCLKDIV);
  end

endmodule

// ### logic/sfd_pkg.sv
// Shared constants, types and decode helpers for the special-function register space.
package sfd_pkg;

  // Register window and register addresses.
  localparam logic [7:0] SFD_WIN_BASE = 8'h80;
  localparam logic [7:0] SFD_ADDR_FLASH = 8'h86;
  localparam logic [7:0] SFD_ADDR_SHARED_ID = 8'hA1;
  localparam logic [7:0] SFD_ADDR_WAKE = 8'hA9;
  localparam logic [7:0] SFD_ADDR_GCFG = 8'hB1;
  localparam logic [7:0] SFD_ADDR_CLKCFG = 8'hB9;
  localparam logic [7:0] SFD_ADDR_PSW = 8'hD0;
  localparam logic [7:0] SFD_ADDR_ACC = 8'hE0;
  localparam logic [7:0] SFD_ADDR_AUXB = 8'hF0;
  localparam logic [7:0] SFD_ADDR_SCLKDIV = 8'hFB;

  // Values after reset.
  localparam logic [7:0] SFD_RST_CORE = 8'h00;
  localparam logic [7:0] SFD_RST_GCFG = 8'h80;
  localparam logic [7:0] SFD_RST_CLKCFG = 8'h83;
  localparam logic [7:0] SFD_RST_WAKE = 8'h00;
  localparam logic [7:0] SFD_RST_UNLOCK = 8'h00;
  localparam logic [7:0] SFD_RST_SCLKDIV = 8'h00;
  localparam logic [7:0] SFD_RST_FLASH = 8'h00;

  // Global configuration field positions set from the straps at reset.
  localparam int SFD_GCFG_BOOT_BIT = 5;
  localparam int SFD_GCFG_SMALL_BIT = 6;

  // Unlock sequence keys and the length of the safe-mode window in cycles.
  localparam logic [7:0] SFD_KEY1 = 8'h55;
  localparam logic [7:0] SFD_KEY2 = 8'hAA;
  localparam int SFD_SAFE_CYCLES = 16;

  // Part identification codes; both values are arbitrary.
  localparam logic [7:0] SFD_ID_LARGE = 8'h3C;
  localparam logic [7:0] SFD_ID_SMALL = 8'h3D;

  // Unlock sequencer states.
  typedef enum logic [1:0] {
    SFD_LOCKED,
    SFD_KEY1_SEEN,
    SFD_SAFE
  } sfd_unlock_t;

  // One access from the core.
  typedef struct packed {
    logic direct;
    logic rd;
    logic wr;
    logic bit_op;
    logic [2:0] bit_idx;
    logic bit_val;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfd_req_t;

  // Decoded register selects.
  typedef struct packed {
    logic hit;
    logic bitable;
    logic flash;
    logic shared_id;
    logic wake;
    logic gcfg;
    logic clkcfg;
    logic program_status_word;
    logic acc;
    logic auxb;
    logic sclkdiv;
  } sfd_sel_t;

  // Configuration levels handed to the rest of the chip.
  typedef struct packed {
    logic safe_active;
    logic [7:0] gcfg;
    logic [7:0] clkcfg;
    logic [7:0] wake;
    logic [7:0] sclkdiv;
    logic [7:0] flash_ctrl;
  } sfd_cfg_t;

  // Addresses ending in 0 or 8 carry the single-bit path.
  function automatic logic sfd_bit_addressable(input logic [7:0] addr);
    return addr[2:0] == 3'h0;
  endfunction

  // Replaces one bit of a byte, keeping the other seven.
  function automatic logic [7:0] sfd_merge_bit(input logic [7:0] old, input logic [2:0] idx, input logic val);
    logic [7:0] res;
    res = old;
    res[idx] = val;
    return res;
  endfunction

endpackage

// ### test/sfd_core_model.sv
// Behavioural model of the processor core that issues register accesses to the bank.
`timescale 1ns/1ps
module sfd_core_model (
  // Clock.
  input wire logic mclk,
  // Access port towards the register bank.
  output sfd_pkg::sfd_req_t req,
  input wire logic [7:0] rdata,
  input wire logic rvalid
);
  import sfd_pkg::*;

  // Start idle so the bank sees defined levels from time zero.
  initial begin
    req = '0;
  end

  // Drop the strobes and invert address and data, so a stale request never looks valid.
  task automatic idle();
    req = '{1'b0, 1'b0, 1'b0, 1'b0, ~req.bit_idx, ~req.bit_val, ~req.addr, ~req.wdata};
  endtask

  // Called at a falling edge: present one request for one cycle, then take the answer.
  task automatic op(input logic dir, input logic rd, input logic wr, input logic bop, input logic [2:0] idx,
                    input logic val, input logic [7:0] addr, input logic [7:0] wdata,
                    output logic [7:0] rd_data, output logic rv);
    req = '{dir, rd, wr, bop, idx, val, addr, wdata};
    @(negedge mclk);
    rd_data = rdata;
    rv = rvalid;
  endtask
endmodule

// ### test/testbench.sv
// Self-checking testbench for the special-function register bank.
`timescale 1ns/1ps
module testbench;
  import sfd_pkg::*;
  logic mclk;
  logic rst_n;
  logic boot_start;
  logic [7:0] flash_status;
  sfd_req_t req;
  logic [7:0] rdata, acc, program_status_word, aux_b, rd_v;
  logic rvalid, rv;
  sfd_cfg_t cfg;
  int bad_count, n_compared, cycles, n;

  sfd_bank #(.SAFE_CYCLES(16), .SMALL_VARIANT(1'b0)) u_dut (.mclk(mclk), .rst_n(rst_n),
    .boot_start(boot_start), .req(req), .rdata(rdata), .rvalid(rvalid), .flash_status(flash_status),
    .acc(acc), .program_status_word(program_status_word), .aux_b(aux_b), .cfg(cfg));
  sfd_core_model u_core (.mclk(mclk), .req(req), .rdata(rdata), .rvalid(rvalid));

  // Free-running 20 MHz clock.
  initial begin
    mclk = 1'b0;
  end
  always #25 mclk = ~mclk;

  // Prints the counts and the verdict, then ends the run.
  task automatic close_out();
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Cuts a hang short; the whole sequence needs well under 200 cycles.
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      bad_count++;
      close_out();
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic dir = 1'b1);
    u_core.op(dir, 1'b0, 1'b1, 1'b0, 3'h0, 1'b0, a, d, rd_v, rv);
  endtask

  task automatic bw(input logic [7:0] a, input logic [2:0] idx, input logic val);
    u_core.op(1'b1, 1'b0, 1'b1, 1'b1, idx, val, a, 8'hC3, rd_v, rv);
  endtask

  // Read, then compare both the data and the valid flag sampled with it.
  task automatic rd(input logic [7:0] a, input logic dir, input logic [7:0] exp);
    u_core.op(dir, 1'b1, 1'b0, 1'b0, 3'h0, 1'b0, a, 8'h00, rd_v, rv);
    chk(rd_v, exp);
    chk({7'h00, rv}, 8'h01);
  endtask

  task automatic do_reset(input logic boot);
    u_core.idle();
    rst_n = 1'b0;
    boot_start = boot;
    repeat (6) @(negedge mclk);
    rst_n = 1'b1;
    @(negedge mclk);
  endtask

  // Main sequence; every step starts at a falling edge.
  initial begin
    bad_count = 0;
    n_compared = 0;
    cycles = 0;
    rst_n = 1'b0;
    boot_start = 1'b0;
    flash_status = 8'hC3;
    do_reset(1'b0);
    chk(acc, 8'h00);
    chk(program_status_word, 8'h00);
    chk(aux_b, 8'h00);
    chk(cfg.gcfg, 8'h80);
    chk({7'h00, cfg.safe_active}, 8'h00);
    wr(8'hE0, 8'h5A);
    rd(8'hE0, 1'b1, 8'h5A);
    wr(8'hD0, 8'hC4);
    bw(8'hD0, 3'h3, 1'b1);
    bw(8'hD0, 3'h7, 1'b0);
    chk(program_status_word, 8'h4C);
    bw(8'hF0, 3'h0, 1'b1);
    chk(aux_b, 8'h01);
    bw(8'hE0, 3'h0, 1'b1);
    chk(acc, 8'h5B);
    // Write and read back to back, so the alias read-back property sees its trigger.
    wr(8'hFB, 8'h37);
    rd(8'hFB, 1'b1, 8'h37);
    bw(8'hFB, 3'h0, 1'b0);
    chk(cfg.sclkdiv, 8'h37);
    wr(8'hE0, 8'h11, 1'b0);
    chk(acc, 8'h5B);
    rd(8'hE0, 1'b0, 8'h00);
    rd(8'h70, 1'b1, 8'h00);
    wr(8'hB1, 8'h12);
    chk(cfg.gcfg, 8'h80);
    wr(8'hA1, SFD_KEY1);
    wr(8'hA1, SFD_KEY2);
    chk({7'h00, cfg.safe_active}, 8'h01);
    wr(8'hB1, 8'h12);
    wr(8'hB9, 8'h34);
    wr(8'hA9, 8'h56);
    u_core.idle();
    // Three open cycles are already spent by the writes above; a key write then lands on the
    // last open cycle, where it must not keep the window from closing.
    n = 3;
    while (cfg.safe_active === 1'b1 && n < 40) begin
      n++;
      if (n == 16) begin
        wr(8'hA1, SFD_KEY1);
        u_core.idle();
      end else begin
        @(negedge mclk);
      end
    end
    chk(n[7:0], 8'h10);
    chk(cfg.gcfg, 8'h12);
    chk(cfg.clkcfg, 8'h34);
    chk(cfg.wake, 8'h56);
    wr(8'hB1, 8'h77);
    chk(cfg.gcfg, 8'h12);
    rd(8'hA1, 1'b1, SFD_ID_LARGE);
    wr(8'h86, 8'h9E);
    chk(cfg.flash_ctrl, 8'h9E);
    rd(8'h86, 1'b1, 8'hC3);
    wr(8'hC5, 8'hFF);
    rd(8'hC5, 1'b1, 8'h00);
    do_reset(1'b1);
    chk(cfg.gcfg, 8'hA0);
    chk(acc, 8'h00);
    chk(program_status_word, 8'h00);
    chk(cfg.sclkdiv, 8'h00);
    close_out();
  end
endmodule
